// [src/diel_pkg.sv]
// package: offsets, fields and codes of the directive identify/enable block
package diel_pkg;

  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [11:0] OFF_CMD = 12'h000;
  localparam logic [11:0] OFF_NSSEL = 12'h004;
  localparam logic [11:0] OFF_DW11 = 12'h008;
  localparam logic [11:0] OFF_DW12 = 12'h00c;
  localparam logic [11:0] OFF_STATUS = 12'h010;
  localparam logic [11:0] OFF_CSEL = 12'h014;
  localparam logic [11:0] OFF_HOSTID = 12'h018;
  localparam logic [11:0] OFF_CCFG = 12'h01c;
  localparam logic [11:0] OFF_RIDX = 12'h020;
  localparam logic [11:0] OFF_RDATA = 12'h024;
  localparam logic [11:0] OFF_SPARAM = 12'h028;

  // ****************************************
  // field positions
  // ****************************************
  localparam int CMD_GO = 0;
  localparam int CMD_SEND = 1;
  localparam int CMD_CTRL_LSB = 4;
  localparam int CMD_CTRL_W = 4;
  localparam int CMD_OP_LSB = 16;
  localparam int CMD_TYPE_LSB = 24;
  localparam int DW12_EN = 0;
  localparam int DW12_TYPE_LSB = 8;
  localparam int ST_DONE = 0;
  localparam int ST_INVALID = 1;
  localparam int ST_UNHANDLED = 2;
  localparam int CCFG_EN = 0;
  localparam int CCFG_CRST = 1;
  localparam int CCFG_SRST = 2;
  localparam int CCFG_ROW_LSB = 16;
  localparam int SP_GRAN_LSB = 16;
  localparam int RPT_IDX_W = 10;

  // ****************************************
  // codes and reset values
  // ****************************************
  localparam logic [7:0] DIRECTIVE_TYPE_FIELD_IDENT = 8'h00;
  localparam logic [7:0] DIRECTIVE_TYPE_FIELD_STREAMS = 8'h01;
  localparam logic [7:0] OP_RET_PARAMS = 8'h01;
  localparam logic [7:0] OP_ENABLE = 8'h01;
  localparam logic [31:0] NS_ALL = 32'h0fffffff;
  localparam logic [9:0] RPT_SUP_WORD = 10'h000;
  localparam logic [9:0] RPT_EN_WORD = 10'h008;
  localparam logic [31:0] RST_WORD = 32'h00000000;

endpackage : diel_pkg

// [src/diel_top.sv]
// file: directive identify/enable command logic behind an apb register slave
//
// Local design decisions: register access over APB and the register offsets.
`timescale 1ns/1ps
// Notes on behaviour
// - identify type 00h, streams type 01h
// - identify receive op 01h returns parameters
// - identify send op 01h enables directive
// - report: supported words, enabled words, rest reserved
// - receive for all-namespaces selector is invalid
// - doubleword 11 value is ignored
// - supported: bit0 one, bit1 streams supported
// - enabled: bit0 one, bit1 streams enabled
// - enable applies to whole host group
// - identify directive is always enabled
// - enabled group controllers share enable state; a crst in the enabling ccfg write can leave a differing row
// - all-namespaces enable hits every controller
// - subsystem reset clears all streams enables
// - controller reset clears unless enabled peer
// - new host id adopts peer state; here only for an enabled controller
// - enabling controller adopts peer state; with crst in the same write the own row is kept
// - changes propagate to same-host controllers
// - target type zero rejected, reserved bits
// - enable bit one enables, zero disables
// - enabling unsupported type is invalid
// - granule is integer multiple of write unit
// - unsupported or disabled type commands rejected
module diel_top #(
  parameter int NUM_CTRL = 4,
  parameter int NUM_NS = 4,
  parameter int HOSTID_W = 16,
  parameter bit STREAMS_SUP = 1'b1,
  parameter int STREAM_WRITE_UNIT = 8,
  parameter int GRAN_MULT = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  // ****************************************
  // sizes and fixed parameters
  // ****************************************
  localparam int CIW = (NUM_CTRL > 1) ? $clog2(NUM_CTRL) : 1;
  localparam int NSW = (NUM_NS > 1) ? $clog2(NUM_NS) : 1;
  localparam logic [15:0] SWU = 16'(STREAM_WRITE_UNIT);
  // granule derived from the unit so it can never be a fraction of it
  localparam logic [15:0] GRAN = 16'(STREAM_WRITE_UNIT * GRAN_MULT);

  // ****************************************
  // state
  // ****************************************
  logic [31:0] cmd_reg;
  logic [31:0] nssel;
  logic [31:0] dw11;
  logic [31:0] dw12;
  logic [2:0] status;
  logic [CIW-1:0] ctrl_sel;
  logic [HOSTID_W-1:0] hostid [NUM_CTRL];
  logic [NUM_CTRL-1:0] ctrl_en;
  logic [NUM_CTRL-1:0][NUM_NS-1:0] stream_en;
  logic [NUM_CTRL-1:0][NUM_NS-1:0] next_stream_en;
  localparam int RPT_IDX_W_L = diel_pkg::RPT_IDX_W;
  logic [RPT_IDX_W_L-1:0] rpt_idx;
  logic rep_en;


  // ****************************************
  // helpers
  // ****************************************
  // zero id means a lone host, so it never joins a group
  function automatic logic same_host(input logic [HOSTID_W-1:0] a,
                                     input logic [HOSTID_W-1:0] b);
    return (a != '0) && (a == b);
  endfunction : same_host

  // identify report word, everything beyond the two vectors is zero
  function automatic logic [31:0] rpt_word(input logic [9:0] idx,
                                           input logic en);
    logic [31:0] w;
    w = diel_pkg::RST_WORD;
    if (idx == diel_pkg::RPT_SUP_WORD) begin
      w = {30'h0, STREAMS_SUP, 1'b1};
    end else if (idx == diel_pkg::RPT_EN_WORD) begin
      w = {30'h0, en, 1'b1};
    end
    return w;
  endfunction : rpt_word

  // ****************************************
  // apb decode
  // ****************************************
  wire setup = psel & ~penable;
  wire access = psel & penable;
  wire addr_ok = (paddr == diel_pkg::OFF_CMD) || (paddr == diel_pkg::OFF_NSSEL) ||
                 (paddr == diel_pkg::OFF_DW11) || (paddr == diel_pkg::OFF_DW12) ||
                 (paddr == diel_pkg::OFF_STATUS) || (paddr == diel_pkg::OFF_CSEL) ||
                 (paddr == diel_pkg::OFF_HOSTID) || (paddr == diel_pkg::OFF_CCFG) ||
                 (paddr == diel_pkg::OFF_RIDX) || (paddr == diel_pkg::OFF_RDATA) ||
                 (paddr == diel_pkg::OFF_SPARAM);
  wire wr = access & pwrite & addr_ok;
  wire wr_cmd = wr & (paddr == diel_pkg::OFF_CMD);
  wire wr_status = wr & (paddr == diel_pkg::OFF_STATUS);
  wire wr_hostid = wr & (paddr == diel_pkg::OFF_HOSTID);
  wire wr_ccfg = wr & (paddr == diel_pkg::OFF_CCFG);
  // no wait states: a fixed answer keeps the access phase one cycle
  assign pready = 1'b1;

  // ****************************************
  // command fields, taken from the go write itself
  // ****************************************
  wire exec = wr_cmd & pwdata[diel_pkg::CMD_GO];
  wire c_send = pwdata[diel_pkg::CMD_SEND];
  wire [3:0] c_ctrl_raw = pwdata[diel_pkg::CMD_CTRL_LSB +: diel_pkg::CMD_CTRL_W];
  wire [CIW-1:0] c_ctrl = c_ctrl_raw[CIW-1:0];
  wire ctrl_ok = 32'(c_ctrl_raw) < NUM_CTRL;
  wire [7:0] c_op = pwdata[diel_pkg::CMD_OP_LSB +: 8];
  wire [7:0] c_type = pwdata[diel_pkg::CMD_TYPE_LSB +: 8];
  wire is_ident = c_type == diel_pkg::DIRECTIVE_TYPE_FIELD_IDENT;
  wire is_streams = c_type == diel_pkg::DIRECTIVE_TYPE_FIELD_STREAMS;

  // namespace selector decode, selectors are 1-based
  wire ns_all = nssel == diel_pkg::NS_ALL;
  wire ns_valid = (nssel != 32'h0) && (nssel <= 32'(NUM_NS));
  wire [31:0] ns_m1 = nssel - 32'h1;
  wire [NSW-1:0] ns_idx = ns_m1[NSW-1:0];

  // doubleword 12: bits 31:16 and 7:1 are not looked at
  wire [7:0] tgt_type = dw12[diel_pkg::DW12_TYPE_LSB +: 8];
  wire directive_enable_bit = dw12[diel_pkg::DW12_EN];
  wire tgt_ok = (tgt_type == diel_pkg::DIRECTIVE_TYPE_FIELD_STREAMS) && STREAMS_SUP;

  // ****************************************
  // command checks
  // ****************************************
  // receive: reserved op or broadcast / unknown namespace
  wire recv_bad = (c_op != diel_pkg::OP_RET_PARAMS) || ns_all || !ns_valid;
  // send: reserved op, identify target, unsupported target
  wire send_bad = (c_op != diel_pkg::OP_ENABLE) ||
                  (tgt_type == diel_pkg::DIRECTIVE_TYPE_FIELD_IDENT) ||
                  !tgt_ok ||
                  (!ns_all && !ns_valid);
  wire cur_en = ctrl_ok && ns_valid && stream_en[c_ctrl][ns_idx];
  // streams commands need support and an enable on that namespace
  wire strm_bad = !STREAMS_SUP || !cur_en;
  wire ident_bad = c_send ? send_bad : recv_bad;
  wire inv = !ctrl_ok ||
             (is_ident ? ident_bad : (is_streams ? strm_bad : 1'b1));
  // streams operations proper live in another block
  wire unhandled = !inv && is_streams;
  wire do_send = exec && !inv && is_ident && c_send;
  wire do_recv = exec && !inv && is_ident && !c_send;

  // ****************************************
  // per-controller configuration events
  // ****************************************
  wire srst = wr_ccfg & pwdata[diel_pkg::CCFG_SRST];
  wire crst = wr_ccfg & pwdata[diel_pkg::CCFG_CRST];
  wire en_rise = wr_ccfg & pwdata[diel_pkg::CCFG_EN] & ~ctrl_en[ctrl_sel];
  wire [HOSTID_W-1:0] cand_id = wr_hostid ? pwdata[HOSTID_W-1:0] : hostid[ctrl_sel];
  logic peer_found;
  logic [CIW-1:0] peer_idx;

  // first enabled controller that shares the candidate id
  always_comb begin
    peer_found = 1'b0;
    peer_idx = '0;
    for (int j = 0; j < NUM_CTRL; j++) begin
      if (!peer_found && (j != int'(ctrl_sel)) && ctrl_en[j] &&
          same_host(cand_id, hostid[j])) begin
        peer_found = 1'b1;
        peer_idx = CIW'(j);
      end
    end
  end

  // adopt peer state on a new id while enabled, or on enabling the controller
  wire adopt = peer_found && ((wr_hostid && ctrl_en[ctrl_sel]) || en_rise);

  // ****************************************
  // next enable state
  // ****************************************
  // one apb write per cycle, but one ccfg write can raise srst, crst and an enable edge together; srst wins, then crst
  always_comb begin
    next_stream_en = stream_en;
    if (srst) begin
      next_stream_en = '0;
    end else if (do_send) begin
      for (int j = 0; j < NUM_CTRL; j++) begin
        for (int n = 0; n < NUM_NS; n++) begin
          if (ns_all) begin
            next_stream_en[j][n] = directive_enable_bit;
          end else if ((n == int'(ns_idx)) &&
                       ((j == int'(c_ctrl)) || same_host(hostid[c_ctrl], hostid[j]))) begin
            next_stream_en[j][n] = directive_enable_bit;
          end
        end
      end
    end else if (crst) begin
      if (!peer_found) begin
        next_stream_en[ctrl_sel] = '0;
      end
    end else if (adopt) begin
      next_stream_en[ctrl_sel] = stream_en[peer_idx];
    end
  end

  // ****************************************
  // register writes
  // ****************************************
  // command and parameter registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_reg <= diel_pkg::RST_WORD;
      nssel <= diel_pkg::RST_WORD;
      dw11 <= diel_pkg::RST_WORD;
      dw12 <= diel_pkg::RST_WORD;
      ctrl_sel <= '0;
      rpt_idx <= '0;
    end else begin
      if (wr_cmd) cmd_reg <= pwdata;
      if (wr & (paddr == diel_pkg::OFF_NSSEL)) nssel <= pwdata;
      if (wr & (paddr == diel_pkg::OFF_DW11)) dw11 <= pwdata;
      if (wr & (paddr == diel_pkg::OFF_DW12)) dw12 <= pwdata;
      if (wr & (paddr == diel_pkg::OFF_CSEL)) ctrl_sel <= pwdata[CIW-1:0];
      if (wr & (paddr == diel_pkg::OFF_RIDX)) rpt_idx <= pwdata[RPT_IDX_W_L-1:0];
    end
  end

  // completion status, a new completion wins over a clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= '0;
    end else begin
      status[diel_pkg::ST_DONE] <= exec |
        (status[diel_pkg::ST_DONE] & ~(wr_status & pwdata[diel_pkg::ST_DONE]));
      if (exec) begin
        status[diel_pkg::ST_INVALID] <= inv;
        status[diel_pkg::ST_UNHANDLED] <= unhandled;
      end
    end
  end

  // report latch: enabled bit of the addressed namespace
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rep_en <= 1'b0;
    end else if (do_recv) begin
      rep_en <= stream_en[c_ctrl][ns_idx];
    end
  end

  // controller ids, enables and the shared enable table
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int j = 0; j < NUM_CTRL; j++) hostid[j] <= '0;
      ctrl_en <= '0;
      stream_en <= '0;
    end else begin
      if (wr_hostid) hostid[ctrl_sel] <= pwdata[HOSTID_W-1:0];
      if (wr_ccfg) ctrl_en[ctrl_sel] <= pwdata[diel_pkg::CCFG_EN];
      stream_en <= next_stream_en;
    end
  end

  // ****************************************
  // read path
  // ****************************************
  // identify bit is not stored anywhere, so nothing can clear it
  wire [31:0] rd_rpt = rpt_word(rpt_idx, rep_en);
  wire [31:0] rd_ccfg = {{(16 - NUM_NS){1'b0}}, stream_en[ctrl_sel], 15'h0,
                         ctrl_en[ctrl_sel]};
  wire [31:0] rd_sparam = {GRAN, SWU};
  wire [31:0] rd_mux =
    (paddr == diel_pkg::OFF_CMD) ? cmd_reg :
    (paddr == diel_pkg::OFF_NSSEL) ? nssel :
    (paddr == diel_pkg::OFF_DW11) ? dw11 :
    (paddr == diel_pkg::OFF_DW12) ? dw12 :
    (paddr == diel_pkg::OFF_STATUS) ? {29'h0, status} :
    (paddr == diel_pkg::OFF_CSEL) ? 32'(ctrl_sel) :
    (paddr == diel_pkg::OFF_HOSTID) ? 32'(hostid[ctrl_sel]) :
    (paddr == diel_pkg::OFF_CCFG) ? rd_ccfg :
    (paddr == diel_pkg::OFF_RIDX) ? 32'(rpt_idx) :
    (paddr == diel_pkg::OFF_RDATA) ? rd_rpt :
    (paddr == diel_pkg::OFF_SPARAM) ? rd_sparam : diel_pkg::RST_WORD;

  // read data and error captured in setup, held through access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= diel_pkg::RST_WORD;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata <= pwrite ? diel_pkg::RST_WORD : rd_mux;
      pslverr <= ~addr_ok;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // group consistency among enabled same-host controllers
  logic group_ok;
  always_comb begin
    group_ok = 1'b1;
    for (int j = 0; j < NUM_CTRL; j++) begin
      for (int k = 0; k < NUM_CTRL; k++) begin
        if (ctrl_en[j] && ctrl_en[k] && same_host(hostid[j], hostid[k]) &&
            (stream_en[j] != stream_en[k])) begin
          group_ok = 1'b0;
        end
      end
    end
  end

  a_group_consistent: assert property (group_ok)
    else $error("enabled same-host controllers disagree");

  a_recv_all_ns: assert property (
    exec && ctrl_ok && is_ident && !c_send && ns_all
    |=> status[diel_pkg::ST_INVALID] && status[diel_pkg::ST_DONE])
    else $error("broadcast report request not rejected");

  a_type_zero_rej: assert property (
    exec && is_ident && c_send && (tgt_type == diel_pkg::DIRECTIVE_TYPE_FIELD_IDENT)
    |=> status[diel_pkg::ST_INVALID] && (stream_en == $past(stream_en)))
    else $error("identify target in enable not rejected");

  a_enable_unsup: assert property (
    exec && is_ident && c_send && directive_enable_bit && !tgt_ok
    |=> status[diel_pkg::ST_INVALID])
    else $error("enable of unsupported type accepted");

  a_resv_op_rej: assert property (
    exec && is_ident &&
    (c_op != (c_send ? diel_pkg::OP_ENABLE : diel_pkg::OP_RET_PARAMS))
    |=> status[diel_pkg::ST_INVALID])
    else $error("reserved identify op accepted");

  a_streams_gate: assert property (
    exec && is_streams && ctrl_ok && ns_valid && !stream_en[c_ctrl][ns_idx]
    |=> status[diel_pkg::ST_INVALID])
    else $error("disabled streams command accepted");

  a_send_target: assert property (
    do_send && !ns_all
    |=> stream_en[$past(c_ctrl)][$past(ns_idx)] == $past(directive_enable_bit))
    else $error("enable did not reach target namespace");

  a_send_all_ns: assert property (
    do_send && ns_all |=> stream_en == {(NUM_CTRL * NUM_NS){$past(directive_enable_bit)}})
    else $error("broadcast enable missed a controller");

  a_subsys_clear: assert property (srst |=> stream_en == '0)
    else $error("subsystem reset left an enable");

  a_ctrl_reset_row: assert property (
    crst && !srst |=> stream_en[$past(ctrl_sel)] ==
      ($past(peer_found) ? $past(stream_en[ctrl_sel]) : '0))
    else $error("controller reset row wrong");

  a_report_en_word: assert property (
    setup && !pwrite && (paddr == diel_pkg::OFF_RDATA) &&
    (rpt_idx == diel_pkg::RPT_EN_WORD)
    |=> prdata == {30'h0, rep_en, 1'b1})
    else $error("enabled vector word wrong");

  a_report_sup_word: assert property (
    setup && !pwrite && (paddr == diel_pkg::OFF_RDATA) &&
    (rpt_idx == diel_pkg::RPT_SUP_WORD)
    |=> prdata == {30'h0, STREAMS_SUP, 1'b1})
    else $error("supported vector word wrong");

  a_granule_mult: assert property (
    setup && !pwrite && (paddr == diel_pkg::OFF_SPARAM)
    |=> (prdata[31:16] % prdata[15:0]) == 16'h0000)
    else $error("granule not a multiple of write unit");

  c_recv_ok: cover property (do_recv ##1 status[diel_pkg::ST_DONE]);
  c_send_all: cover property (do_send && ns_all && directive_enable_bit);
  c_crst_keep: cover property (crst && peer_found);
  c_adopt: cover property (adopt && en_rise);

endmodule : diel_top

// [tb/diel_host_model.sv]
// host side model: apb master that issues the directive register transfers
`timescale 1ns/1ps
module diel_host_model (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // ****************************************
  // idle bus at time zero
  // ****************************************
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
  end

  // ****************************************
  // one transfer, entered just after a rising edge
  // ****************************************
  // request held until pready is seen high; one idle edge after release
  // so that a following call never drives psel twice in one step
  // no cycle limit here: only the bench watchdog ends a stuck wait
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;  // released lines carry junk, not the last value
    pwdata <= ~d;
    @(posedge pclk);
  endtask : xfer
endmodule : diel_host_model

// [tb/diel_tb_top.sv]
// self-checking bench: reference model of directive enable state vs the block
`timescale 1ns/1ps
module diel_tb_top;
  localparam int NC = 4;
  localparam int NNS = 4;
  localparam int WU = 8;
  localparam int GM = 4;
  localparam bit SUP = 1'b1;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  int errors;
  int samples_checked;
  bit en_m[NC][NNS];
  bit cen[NC];
  int hid_m[NC];

  diel_top #(.NUM_CTRL(NC), .NUM_NS(NNS), .HOSTID_W(16), .STREAMS_SUP(SUP),
    .STREAM_WRITE_UNIT(WU), .GRAN_MULT(GM)) i_diel_top (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));

  diel_host_model i_diel_host_model (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));

  // ****************************************
  // clock and hang guard
  // ****************************************
  always #10 pclk = ~pclk;

  // far above the fewer than one thousand cycles the sequence needs
  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    end_of_test();
  end

  // ****************************************
  // bus and compare helpers
  // ****************************************
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    i_diel_host_model.xfer(1'b1, a, d, r, e);
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [31:0] r);
    logic e;
    i_diel_host_model.xfer(1'b0, a, 32'h00000000, r, e);
  endtask : rd

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic end_of_test;
    if (errors == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_of_test

  // ****************************************
  // reference model of enable state
  // ****************************************
  function automatic logic [15:0] row(input int c);
    row = 16'h0000;
    for (int n = 0; n < NNS; n++) row[n] = en_m[c][n];
  endfunction : row

  function automatic bit peer(input int c, input int k);
    peer = k != c && hid_m[c] != 0 && hid_m[k] == hid_m[c];
  endfunction : peer

  // copy the row of the first enabled peer with the same host id
  task automatic adopt(input int c);
    for (int k = NC - 1; k >= 0; k--) begin
      if (peer(c, k) && cen[k]) en_m[c] = en_m[k];
    end
  endtask : adopt

  // ccfg write: srst wins over crst, enable edge adopts peer state
  task automatic ccfg(input int c, input logic [2:0] v);
    bit kept;
    wr(diel_pkg::OFF_CSEL, 32'(c));
    wr(diel_pkg::OFF_CCFG, {29'h0, v});
    kept = 1'b0;
    for (int k = 0; k < NC; k++) kept |= peer(c, k) && cen[k];
    // a reset in the same write takes priority over the enable edge
    if (v[2]) en_m = '{default: 1'b0};
    else if (v[1]) begin
      if (!kept) en_m[c] = '{default: 1'b0};
    end else if (v[0] && !cen[c]) begin
      adopt(c);
    end
    cen[c] = v[0];
  endtask : ccfg

  task automatic ctl(input int c, input int h, input bit en);
    wr(diel_pkg::OFF_CSEL, 32'(c));
    wr(diel_pkg::OFF_HOSTID, 32'(h));
    hid_m[c] = h;
    if (cen[c]) adopt(c);
    ccfg(c, {2'b00, en});
  endtask : ctl

  task automatic rows;
    logic [31:0] r;
    for (int c = 0; c < NC; c++) begin
      wr(diel_pkg::OFF_CSEL, 32'(c));
      rd(diel_pkg::OFF_CCFG, r);
      chk(r, {row(c), 15'h0000, cen[c]});
    end
  endtask : rows

  task automatic rep_chk(input bit e);
    logic [31:0] r;
    wr(diel_pkg::OFF_RIDX, 32'(diel_pkg::RPT_EN_WORD));
    rd(diel_pkg::OFF_RDATA, r);
    chk(r, {30'h0, e, 1'b1});
    wr(diel_pkg::OFF_RIDX, 32'(diel_pkg::RPT_SUP_WORD));
    rd(diel_pkg::OFF_RDATA, r);
    chk(r, {30'h0, SUP, 1'b1});
    wr(diel_pkg::OFF_RIDX, $urandom_range(1023, 9));
    rd(diel_pkg::OFF_RDATA, r);
    chk(r, 32'h00000000);
  endtask : rep_chk

  // issue one command; dw11 is random every time and must not matter
  task automatic cmd(input logic [3:0] c, input bit snd, input logic [7:0] op,
                     input logic [7:0] typ, input logic [31:0] ns, input logic [7:0] tgt,
                     input bit enb);
    logic [31:0] r;
    bit inv;
    bit nsok;
    nsok = ns >= 1 && ns <= NNS;
    if (c >= NC || typ > 8'h01) inv = 1'b1;
    else if (typ == diel_pkg::DIRECTIVE_TYPE_FIELD_STREAMS) inv = !nsok || !en_m[c][ns-1];
    else if (snd) inv = op != 8'h01 || tgt != 8'h01 || !(nsok || ns == diel_pkg::NS_ALL);
    else inv = op != 8'h01 || !nsok;
    wr(diel_pkg::OFF_NSSEL, ns);
    wr(diel_pkg::OFF_DW11, $urandom);
    wr(diel_pkg::OFF_DW12, {16'h0000, tgt, 7'h00, enb});
    wr(diel_pkg::OFF_CMD, {typ, op, 8'h00, c, 2'b00, snd, 1'b1});
    rd(diel_pkg::OFF_STATUS, r);
    chk({29'h0, r[2:0]}, {29'h0, !inv && typ == diel_pkg::DIRECTIVE_TYPE_FIELD_STREAMS, inv, 1'b1});
    wr(diel_pkg::OFF_STATUS, 32'h00000001);
    if (!inv && snd) begin
      for (int k = 0; k < NC; k++) begin
        if (ns == diel_pkg::NS_ALL) en_m[k] = '{default: enb};
        else if (k == c || peer(c, k)) en_m[k][ns-1] = enb;
      end
    end
    if (!inv && !snd && typ == diel_pkg::DIRECTIVE_TYPE_FIELD_IDENT) rep_chk(en_m[c][ns-1]);
  endtask : cmd

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    logic [31:0] r;
    logic e;
    int hid;
    pclk = 1'b0;
    presetn = 1'b0;
    errors = 0;
    samples_checked = 0;
    void'($urandom(50270));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(diel_pkg::OFF_SPARAM, r);
    chk(r, {16'(WU * GM), 16'(WU)});
    i_diel_host_model.xfer(1'b0, 12'h02c, 32'h00000000, r, e);
    chk({r[30:0], e}, 32'h00000001);
    hid = $urandom_range(255, 1);
    ctl(0, hid, 1'b1);
    ctl(1, hid, 1'b1);
    ctl(2, 0, 1'b1);
    cmd(0, 1, 8'h01, 8'h00, 2, 8'h01, 1);
    rows();
    cmd(1, 0, 8'h01, 8'h00, 2, 8'h00, 0);
    cmd(2, 0, 8'h01, 8'h00, 2, 8'h00, 0);
    cmd(0, 0, 8'h01, 8'h00, diel_pkg::NS_ALL, 8'h00, 0);
    cmd(0, 1, 8'h01, 8'h00, 1, 8'h00, 1);
    cmd(0, 1, 8'h02, 8'h00, 1, 8'h01, 1);
    cmd(0, 0, 8'h00, 8'h00, 1, 8'h00, 0);
    cmd(0, 1, 8'h01, 8'h00, 1, 8'h02, 1);
    cmd(2, 0, 8'h01, 8'h01, 2, 8'h00, 0);
    cmd(0, 0, 8'h01, 8'h01, 2, 8'h00, 0);
    cmd(0, 0, 8'h01, 8'h02, 1, 8'h00, 0);
    cmd(4, 0, 8'h01, 8'h00, 1, 8'h00, 0);
    for (int i = 0; i < 6; i++) begin
      cmd(4'($urandom_range(2, 0)), 1, 8'h01, 8'h00, $urandom_range(4, 1), 8'h01,
          1'($urandom_range(1, 0)));
    end
    rows();
    cmd(2, 1, 8'h01, 8'h00, diel_pkg::NS_ALL, 8'h01, 1);
    rows();
    ccfg(0, 3'b011);
    ccfg(2, 3'b011);
    ccfg(3, 3'b010);
    rows();
    ctl(2, hid, 1'b1);
    ctl(3, hid, 1'b1);
    rows();
    ccfg(0, 3'b101);
    rows();
    cmd(1, 0, 8'h01, 8'h00, 3, 8'h00, 0);
    end_of_test();
  end
endmodule : diel_tb_top
